/* File: logic/priority_flow_control_unit.sv */
/*
  Priority flow control for one Ethernet port: pause frame generation
  from the congestion vector, pause frame reception with per-priority
  pause counters, stop indications and egress hold, statistics.
  Assumes a byte-wide MAC stream on both sides on the same clock, and
  an Avalon-MM master for the registers.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pfc_consts.svh"

// Summary of operation
// - Pause sending and pause reaction enabled separately, sending per priority.
// - Queue watermark crossing asserts congestion, fed in as a vector.
// - Congestion status held per priority as an 8-bit vector.
// - A priority turning congested triggers a pause frame.
// - Refresh frame after half the pause time if still congested.
// - New congestion while timer runs sends after the minimum interval.
// - One refresh timer shared by all eight priorities.
// - Every frame reports all priorities, enable vector fixed 0x00ff.
// - Disabled priorities carry pause time zero.
// - Pause time and minimum interval configurable, pause time shared.
// - Each sent pause frame increments the sent pause counter.
// - Received pause frames load per-priority pause counters.
// - Pause counters count down at the link speed rate.
// - Nonzero pause counter gives a stop indication.
// - Stopped priorities have their egress queue held.
// - Received pause frames counted as unknown opcode control frames.
module priority_flow_control_unit #(
  parameter int          PRIOS      = 8,
  parameter logic [47:0] SRC_ADDR   = 48'h0200_0000_0001
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [2:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic [PRIOS-1:0]  perPriorityCongestionVector,
  output logic                   txValid,
  output logic      [7:0]        txData,
  output logic                   txLast,
  input  wire logic              txReady,
  input  wire logic              rxValid,
  input  wire logic [7:0]        rxData,
  input  wire logic              rxLast,
  output logic      [PRIOS-1:0]  stopIndication,
  output logic      [PRIOS-1:0]  egressHold
);

  localparam logic [10:0] BITS_10M  = 11'(`PFC_RATE_10M / `PFC_CLK_HZ);
  localparam logic [10:0] BITS_100M = 11'(`PFC_RATE_100M / `PFC_CLK_HZ);
  localparam logic [10:0] BITS_1G   = 11'(`PFC_RATE_1G / `PFC_CLK_HZ);
  localparam logic [10:0] BITS_10G  = 11'(`PFC_RATE_10G / `PFC_CLK_HZ);

  logic [31:0]           ctrl_q;
  pfc_pkg::quanta_t      sentPauseTimeValue_q;
  pfc_pkg::quanta_t      minRefreshInterval_q;
  logic [31:0]           sentPauseFrameCount_q;
  logic [31:0]           rxUnknownOpcodeCount_q;
  logic [31:0]           readData_d;
  logic                  wrCommit;
  logic                  txEnable;
  logic                  rxEnable;
  logic [PRIOS-1:0]      prioEnable;
  logic [1:0]            linkSpeed;
  logic [PRIOS-1:0]      congestion_q;
  logic [PRIOS-1:0]      effCong;
  logic [PRIOS-1:0]      effCongPrev_q;
  logic                  congRise;
  logic [10:0]           bitAcc_q;
  logic [10:0]           bitsPerCycle;
  logic [11:0]           bitSum;
  logic [1:0]            quantaTick;
  pfc_pkg::txState_t     txState_q;
  logic [5:0]            txIdx_q;
  logic [5:0]            txIdxNext;
  logic [PRIOS-1:0]      snapMask_q;
  pfc_pkg::quanta_t      elapsed_q;
  logic                  running_q;
  logic                  earlyPend_q;
  logic                  sendReq;
  logic                  txStart;
  logic                  txDone;
  logic [5:0]            rxIdx_q;
  logic [7:0]            rxPrev_q;
  logic                  typeOk_q;
  logic                  opcOk_q;
  logic [PRIOS-1:0]      rxPev_q;
  pfc_pkg::quanta_t      rxTime_q [PRIOS];
  pfc_pkg::quanta_t      pauseCnt_q [PRIOS];
  logic                  rxPfcEnd;

  // Control fields
  assign txEnable   = ctrl_q[`PFC_CTRL_TXEN];
  assign rxEnable   = ctrl_q[`PFC_CTRL_RXEN];
  assign prioEnable = ctrl_q[`PFC_CTRL_PRIO_LSB +: PRIOS];
  assign linkSpeed  = ctrl_q[`PFC_CTRL_SPEED_LSB +: 2];

  // Bus answer: waitrequest drops for one cycle after a request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  assign wrCommit = write && !waitrequest;

  // Read data mux, unmapped words read zero
  always_comb begin
    readData_d = 32'h0000_0000;
    unique case (address)
      `PFC_REG_CTRL:      readData_d = ctrl_q;
      `PFC_REG_PAUSE_VAL: readData_d = {16'h0000, sentPauseTimeValue_q};
      `PFC_REG_MIN_INT:   readData_d = {16'h0000, minRefreshInterval_q};
      `PFC_REG_TX_CNT:    readData_d = sentPauseFrameCount_q;
      `PFC_REG_RX_CNT:    readData_d = rxUnknownOpcodeCount_q;
      `PFC_REG_STATUS:    readData_d = {16'h0000, stopIndication, congestion_q};
      default:            readData_d = 32'h0000_0000;
    endcase
  end

  // Read data captured as waitrequest drops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= readData_d;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q               <= `PFC_CTRL_RESET;
      sentPauseTimeValue_q <= `PFC_PAUSE_RESET;
      minRefreshInterval_q <= `PFC_MIN_RESET;
    end else if (wrCommit) begin
      if (address == `PFC_REG_CTRL) begin
        ctrl_q <= writedata;
      end
      if (address == `PFC_REG_PAUSE_VAL) begin
        sentPauseTimeValue_q <= writedata[15:0];
      end
      if (address == `PFC_REG_MIN_INT) begin
        minRefreshInterval_q <= writedata[15:0];
      end
    end
  end

  // Quantum ticks from a bit-time accumulator
  always_comb begin
    unique case (linkSpeed)
      `PFC_SPEED_10M:  bitsPerCycle = BITS_10M;
      `PFC_SPEED_100M: bitsPerCycle = BITS_100M;
      `PFC_SPEED_1G:   bitsPerCycle = BITS_1G;
      `PFC_SPEED_10G:  bitsPerCycle = BITS_10G;
    endcase
  end

  assign bitSum     = {1'b0, bitAcc_q} + {1'b0, bitsPerCycle};
  assign quantaTick = bitSum[`PFC_QUANTUM_SHIFT +: 2];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitAcc_q <= 11'h000;
    end else begin
      bitAcc_q <= {2'b00, bitSum[`PFC_QUANTUM_SHIFT-1:0]};
    end
  end

  // Congestion status held per priority
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      congestion_q  <= '0;
      effCongPrev_q <= '0;
    end else begin
      congestion_q  <= perPriorityCongestionVector;
      effCongPrev_q <= effCong;
    end
  end

  assign effCong  = txEnable ? (congestion_q & prioEnable) : '0;
  assign congRise = |(effCong & ~effCongPrev_q);

  // Shared refresh timer and send decision
  assign sendReq = (!running_q && congRise)
                || (running_q && earlyPend_q
                    && elapsed_q >= minRefreshInterval_q)
                || (running_q && |effCong
                    && elapsed_q >= (sentPauseTimeValue_q >> 1));
  assign txStart = (txState_q == pfc_pkg::TX_IDLE) && sendReq;
  assign txDone  = txValid && txReady && txLast;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      elapsed_q   <= '0;
      running_q   <= 1'b0;
      earlyPend_q <= 1'b0;
    end else if (txStart) begin
      elapsed_q   <= '0;
      running_q   <= 1'b1;
      earlyPend_q <= 1'b0;
    end else begin
      if (running_q && congRise) begin
        earlyPend_q <= 1'b1;
      end
      if (running_q && elapsed_q >= sentPauseTimeValue_q && !(|effCong)) begin
        running_q <= 1'b0;
      end
      if (elapsed_q <= 16'hffff - 16'(quantaTick)) begin
        elapsed_q <= elapsed_q + 16'(quantaTick);
      end else begin
        elapsed_q <= 16'hffff;
      end
    end
  end

  // Frame byte generator
  function automatic logic [7:0] txByte(input logic [5:0] idx,
                                        input logic [PRIOS-1:0] mask,
                                        input pfc_pkg::quanta_t pval);
    logic [143:0] hdr;
    logic [5:0]   off;
    hdr = {`PFC_DEST_ADDR, SRC_ADDR, `PFC_ETHERTYPE, `PFC_OPCODE, `PFC_PEV};
    off = 6'h00;
    txByte = 8'h00;
    if (idx < `PFC_HDR_BYTES) begin
      off    = `PFC_HDR_BYTES - 6'd1 - idx;
      txByte = hdr[off*8 +: 8];
    end else if (idx < `PFC_TIME_END) begin
      off = idx - `PFC_HDR_BYTES;
      if (mask[off[3:1]]) begin
        txByte = off[0] ? pval[7:0] : pval[15:8];
      end
    end
  endfunction : txByte

  assign txIdxNext = txStart ? 6'h00 : txIdx_q + 6'h01;

  // Transmit stream, advanced by txReady
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txState_q  <= pfc_pkg::TX_IDLE;
      txIdx_q    <= 6'h00;
      snapMask_q <= '0;
      txValid    <= 1'b0;
      txData     <= 8'h00;
      txLast     <= 1'b0;
    end else begin
      unique case (txState_q)
        pfc_pkg::TX_IDLE: begin
          if (txStart) begin
            txState_q  <= pfc_pkg::TX_SEND;
            txIdx_q    <= txIdxNext;
            snapMask_q <= effCong;
            txValid    <= 1'b1;
            txData     <= txByte(txIdxNext, effCong, sentPauseTimeValue_q);
            txLast     <= 1'b0;
          end
        end
        pfc_pkg::TX_SEND: begin
          if (txDone) begin
            txState_q <= pfc_pkg::TX_IDLE;
            txValid   <= 1'b0;
            txLast    <= 1'b0;
          end else if (txValid && txReady) begin
            txIdx_q <= txIdxNext;
            txData  <= txByte(txIdxNext, snapMask_q, sentPauseTimeValue_q);
            txLast  <= (txIdxNext == `PFC_FRAME_LAST);
          end
        end
      endcase
    end
  end

  // Statistics counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sentPauseFrameCount_q  <= 32'h0000_0000;
      rxUnknownOpcodeCount_q <= 32'h0000_0000;
    end else begin
      if (txDone) begin
        sentPauseFrameCount_q <= sentPauseFrameCount_q + 32'h0000_0001;
      end
      if (rxPfcEnd) begin
        rxUnknownOpcodeCount_q <= rxUnknownOpcodeCount_q + 32'h0000_0001;
      end
    end
  end

  // Receive parser: type, opcode, enable vector, pause times
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxIdx_q  <= 6'h00;
      rxPrev_q <= 8'h00;
      typeOk_q <= 1'b0;
      opcOk_q  <= 1'b0;
      rxPev_q  <= '0;
    end else if (rxValid) begin
      rxPrev_q <= rxData;
      if (rxLast) begin
        rxIdx_q  <= 6'h00;
        typeOk_q <= 1'b0;
        opcOk_q  <= 1'b0;
      end else if (rxIdx_q != 6'h3f) begin
        rxIdx_q <= rxIdx_q + 6'h01;
      end
      if (rxIdx_q == `PFC_RX_TYPE_LO && !rxLast) begin
        typeOk_q <= ({rxPrev_q, rxData} == `PFC_ETHERTYPE);
      end
      if (rxIdx_q == `PFC_RX_OPC_LO && !rxLast) begin
        opcOk_q <= ({rxPrev_q, rxData} == `PFC_OPCODE);
      end
      if (rxIdx_q == `PFC_RX_PEV_LO) begin
        rxPev_q <= rxData[PRIOS-1:0];
      end
    end
  end

  assign rxPfcEnd = rxValid && rxLast && typeOk_q && opcOk_q;

  // Per priority: time capture, pause counter, stop and hold
  for (genvar p = 0; p < PRIOS; p++) begin : g_prio
    localparam logic [5:0] LO_IDX = 6'(`PFC_HDR_BYTES + 2*p + 1);

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        rxTime_q[p] <= '0;
      end else if (rxValid && rxIdx_q == LO_IDX) begin
        rxTime_q[p] <= {rxPrev_q, rxData};
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        pauseCnt_q[p] <= '0;
      end else if (rxPfcEnd && rxEnable && rxPev_q[p]) begin
        pauseCnt_q[p] <= rxTime_q[p];
      end else if (pauseCnt_q[p] > 16'(quantaTick)) begin
        pauseCnt_q[p] <= pauseCnt_q[p] - 16'(quantaTick);
      end else begin
        pauseCnt_q[p] <= '0;
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        stopIndication[p] <= 1'b0;
        egressHold[p]     <= 1'b0;
      end else begin
        stopIndication[p] <= (pauseCnt_q[p] != '0);
        egressHold[p]     <= stopIndication[p];
      end
    end
  end

endmodule : priority_flow_control_unit
`default_nettype wire

/* File: logic/pfc_consts.svh */
/*
  Constants of the priority flow control unit: register map, field
  positions, reset values, frame layout and timing figures.
  Assumes inclusion by bare name from the design and the bench.
*/
`ifndef PFC_CONSTS_SVH
`define PFC_CONSTS_SVH

// Register word indices on the Avalon-MM slave
`define PFC_REG_CTRL        3'h0
`define PFC_REG_PAUSE_VAL   3'h1
`define PFC_REG_MIN_INT     3'h2
`define PFC_REG_TX_CNT      3'h3
`define PFC_REG_RX_CNT      3'h4
`define PFC_REG_STATUS      3'h5

// Control register fields
`define PFC_CTRL_TXEN       0
`define PFC_CTRL_RXEN       1
`define PFC_CTRL_PRIO_LSB   8
`define PFC_CTRL_SPEED_LSB  16

// Reset values
`define PFC_CTRL_RESET      32'h0000_0000
`define PFC_PAUSE_RESET     16'hffff
`define PFC_MIN_RESET       16'h0010

// Speed codes in the control register
`define PFC_SPEED_10M       2'h0
`define PFC_SPEED_100M      2'h1
`define PFC_SPEED_1G        2'h2
`define PFC_SPEED_10G       2'h3

// Clock and line rates in Hz; one pause quantum is 512 bit times
`define PFC_CLK_HZ          10000000
`define PFC_RATE_10M        10000000
`define PFC_RATE_100M       100000000
`define PFC_RATE_1G         1000000000
`define PFC_RATE_10G        64'd10000000000
`define PFC_QUANTUM_SHIFT   9

// Frame layout
`define PFC_DEST_ADDR       48'h0180_c200_0001
`define PFC_ETHERTYPE       16'h8808
`define PFC_OPCODE          16'h0101
`define PFC_PEV             16'h00ff
`define PFC_HDR_BYTES       6'd18
`define PFC_TIME_END        6'd34
`define PFC_FRAME_LAST      6'd59
`define PFC_RX_TYPE_LO      6'd13
`define PFC_RX_OPC_LO       6'd15
`define PFC_RX_PEV_LO       6'd17

`endif

/* File: logic/pfc_pkg.sv */
/*
  Types shared by the priority flow control unit.
  Assumes pfc_consts.svh is on the include path.
*/
package pfc_pkg;
  typedef logic [15:0] quanta_t;
  typedef enum logic {TX_IDLE, TX_SEND} txState_t;
endpackage : pfc_pkg

/* File: verif/pfc_chk.sv */
/*
  Port checker of the priority flow control unit.
  Assumes binding to the top module, one clock, active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module pfc_chk #(
  parameter int PRIOS = 8
) (
  input wire logic             clk,
  input wire logic             resetn,
  input wire logic             read,
  input wire logic             write,
  input wire logic             waitrequest,
  input wire logic [PRIOS-1:0] perPriorityCongestionVector,
  input wire logic             txValid,
  input wire logic [7:0]       txData,
  input wire logic             txLast,
  input wire logic             txReady,
  input wire logic             rxValid,
  input wire logic             rxLast,
  input wire logic [PRIOS-1:0] stopIndication,
  input wire logic [PRIOS-1:0] egressHold
);
  logic [5:0] byteIdx_q;
  logic       rxEnd;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // End of a received frame
  assign rxEnd = rxValid && rxLast;
  // Position of the byte on the transmit stream
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      byteIdx_q <= 6'h00;
    else if (txValid && txReady)
      byteIdx_q <= txLast ? 6'h00 : byteIdx_q + 6'h01;
  end
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer not one cycle");
  bus_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast))
    else $error("tx byte dropped before acceptance");
  frame_len_a: assert property (txValid && txLast |-> byteIdx_q == 6'h3b)
    else $error("pause frame length wrong");
  frame_head_a: assert property ($rose(txValid) |-> txData == 8'h01 && byteIdx_q == 6'h00)
    else $error("frame start byte wrong");
  ctl_type_a: assert property (txValid && byteIdx_q == 6'h0c |-> txData == 8'h88)
    else $error("control type byte wrong");
  opcode_byte_a: assert property (txValid && byteIdx_q inside {6'h0e, 6'h0f} |-> txData == 8'h01)
    else $error("opcode byte wrong");
  enable_vec_a: assert property (txValid && byteIdx_q[5:1] == 5'h08 |->
    txData == (byteIdx_q[0] ? 8'hff : 8'h00))
    else $error("enable vector byte wrong");
  tx_cause_a: assert property ($rose(txValid) |-> $past(perPriorityCongestionVector, 2) != '0)
    else $error("frame without congestion");
  stop_cause_a: assert property ((stopIndication & ~$past(stopIndication)) != '0 |->
    $past(rxEnd, 2) || $past(rxEnd, 3))
    else $error("stop without received frame");
  hold_follow_a: assert property (##1 egressHold == $past(stopIndication))
    else $error("egress hold not following stop");
  cover property (txValid && txReady && txLast);
  cover property ($rose(|stopIndication));
  cover property (read && !waitrequest);
endmodule : pfc_chk
`default_nettype wire

/* File: verif/link_partner_model.sv */
/*
  Link partner MAC model: accepts pause frames with optional random
  stalls and sends control frames on request. Same clock as the unit.
*/
`timescale 1ns/10ps
`default_nettype none
module link_partner_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       stall,
  input  wire logic       go,
  input  wire logic       isPfc,
  input  wire logic [7:0] pev,
  input  wire logic [15:0] pauseTime,
  output var  logic       txReady,
  output var  logic       rxValid,
  output var  logic [7:0] rxData,
  output var  logic       rxLast,
  output var  logic       busy
);
  logic [5:0]   idx_q;
  logic [15:0]  lfsr_q;
  logic [271:0] hdr;
  // Control frame header, times big-endian for every priority
  assign hdr = {48'h0180c2000001, 48'h020000000002, 16'h8808, isPfc ? 16'h0101 : 16'h0001,
                8'h00, pev, {8{pauseTime}}};
  // Acceptance of transmitted bytes, random while stalling
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfsr_q  <= 16'hace1;
      txReady <= 1'b0;
    end else begin
      lfsr_q  <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      txReady <= !stall || lfsr_q[0];
    end
  end
  // Frame sender; idle data toggles so nothing stale looks valid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idx_q   <= 6'h00;
      busy    <= 1'b0;
      rxValid <= 1'b0;
      rxData  <= 8'h00;
      rxLast  <= 1'b0;
    end else if (busy) begin
      rxValid <= 1'b1;
      rxData  <= idx_q < 6'h22 ? hdr[8*(33-idx_q) +: 8] : 8'h00;
      rxLast  <= idx_q == 6'h3b;
      idx_q   <= idx_q + 6'h01;
      busy    <= idx_q != 6'h3b;
    end else begin
      rxValid <= 1'b0;
      rxLast  <= 1'b0;
      rxData  <= ~rxData;
      idx_q   <= 6'h00;
      busy    <= go;
    end
  end
endmodule : link_partner_model
`default_nettype wire

/* File: verif/tb_priority_flow_control_unit.sv */
/*
  Self-checking bench of the priority flow control unit.
  Assumes the package, the constants header and the partner model.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pfc_consts.svh"
module tb_priority_flow_control_unit;
  localparam logic [47:0] SRC = 48'h0200_0000_00a5; // Arbitrary source address
  logic             clk, resetn, read, write, waitrequest, txValid, txLast, txReady;
  logic             rxValid, rxLast, stall, go, isPfc, busy;
  logic [2:0]       address;
  logic [31:0]      writedata, readdata, d, seed;
  logic [7:0]       vec, txData, rxData, stopIndication, egressHold, pev, en, v;
  pfc_pkg::quanta_t pauseTime, pv;
  int               nMismatch, totalChecks, nFrames, txIdx, stamp, cyc, t0, n0;
  logic [7:0]       txBuf [60];
  priority_flow_control_unit #(.SRC_ADDR(SRC)) i_priority_flow_control_unit (
    .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .perPriorityCongestionVector(vec), .txValid(txValid), .txData(txData),
    .txLast(txLast), .txReady(txReady), .rxValid(rxValid), .rxData(rxData),
    .rxLast(rxLast), .stopIndication(stopIndication), .egressHold(egressHold));
  link_partner_model i_link_partner_model (.clk(clk), .resetn(resetn), .stall(stall),
    .go(go), .isPfc(isPfc), .pev(pev), .pauseTime(pauseTime), .txReady(txReady),
    .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .busy(busy));
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycle count and capture of sent frames
  always @(posedge clk) begin
    cyc++;
    if (txValid === 1'b1 && txReady === 1'b1) begin
      if (txIdx == 0) stamp = cyc;
      txBuf[txIdx] = txData;
      txIdx = txLast ? 0 : txIdx + 1;
      if (txLast) nFrames++;
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [7:0] expByte(int i);
    logic [271:0] h;
    h = {48'h0180c2000001, SRC, 16'h8808, 16'h0101, 16'h00ff, 128'h0};
    for (int p = 0; p < 8; p++) if (v[p] && en[p]) h[112-16*p +: 16] = pv;
    return i < 34 ? h[8*(33-i) +: 8] : 8'h00;
  endfunction : expByte
  function automatic logic [31:0] ctrl(logic [1:0] sp, logic rx, logic tx);
    return {14'h0, sp, en, 6'h0, rx, tx};
  endfunction : ctrl
  function automatic logic [31:0] near(int a, int e, int tol);
    return 32'((a >= e - tol) && (a <= e + tol));
  endfunction : near
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    totalChecks++;
    if (s !== e) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : rd
  task automatic wr(input logic [2:0] a, input logic [31:0] w);
    @(posedge clk);
    address   <= a;
    writedata <= w;
    write     <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : wr
  task automatic waitFrames(input int k, input int lim);
    for (int j = 0; j < lim && nFrames < k; j++) @(posedge clk);
    chk("frame count", 32'(nFrames), 32'(k));
  endtask : waitFrames
  task automatic frameChk();
    for (int i = 0; i < 60; i++) chk("tx byte", 32'(txBuf[i]), 32'(expByte(i)));
  endtask : frameChk
  task automatic noFrame();
    repeat (3) @(posedge clk);
    n0 = nFrames;
    repeat (600) @(posedge clk);
    chk("no frame", 32'(nFrames), 32'(n0));
  endtask : noFrame
  task automatic rxFrame(input logic [7:0] p, input pfc_pkg::quanta_t t, input logic pfc);
    @(posedge clk);
    go        <= 1'b1;
    pev       <= p;
    pauseTime <= t;
    isPfc     <= pfc;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask : rxFrame
  task automatic conclude();
    if (nMismatch == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    nMismatch++;
    conclude();
  end
  // Main sequence
  initial begin
    {read, write, go, isPfc, stall, resetn} = '0;
    {address, writedata, vec, pev, pauseTime, v} = '0;
    {cyc, txIdx, nFrames, nMismatch, totalChecks} = '0;
    seed = 32'h2cf9f390;
    en   = 8'h0f;
    pv   = 16'h0400;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      chk("reset value", d, a == 1 ? 32'(`PFC_PAUSE_RESET) : a == 2 ? 32'(`PFC_MIN_RESET) : 0);
    end
    wr(`PFC_REG_TX_CNT, 32'h0000_1234);
    rd(`PFC_REG_TX_CNT);
    chk("read-only count", d, 32'h0);
    wr(`PFC_REG_PAUSE_VAL, 32'(pv));
    wr(`PFC_REG_MIN_INT, 32'h0000_0010);
    wr(`PFC_REG_CTRL, ctrl(2'h3, 1'b1, 1'b1));
    stall <= 1'b1;
    // New enabled priority each pass, random disabled ones beside it
    for (int i = 0; i < 4; i++) begin
      v   = {4'(xs()), v[3:0] | (4'h1 << i)};
      vec <= v;
      t0  = cyc;
      waitFrames(i + 1, 400);
      chk("prompt frame", 32'(stamp - t0 < 40), 32'h1);
      frameChk();
      rd(`PFC_REG_STATUS);
      chk("congestion status", 32'(d[7:0]), 32'(v));
    end
    // Refresh at half the pause time, no stalls
    stall <= 1'b0;
    waitFrames(5, 600);
    t0 = stamp;
    waitFrames(6, 600);
    chk("refresh gap", near(stamp - t0, (int'(pv >> 1) * 512 + 999) / 1000 + 1, 3), 1);
    frameChk();
    rd(`PFC_REG_TX_CNT);
    chk("sent count", d, 32'(nFrames));
    vec <= 8'hf0;
    noFrame();
    wr(`PFC_REG_CTRL, ctrl(2'h3, 1'b1, 1'b0));
    vec <= 8'hff;
    noFrame();
    // Received pauses at every link speed
    for (int s = 0; s < 4; s++) begin
      wr(`PFC_REG_CTRL, ctrl(2'(s), 1'b1, 1'b0));
      rxFrame(8'h05, 16'(4 * 10 ** s), 1'b1);
      t0 = cyc;
      repeat (4) @(posedge clk);
      chk("stop set", 32'(stopIndication), 32'h05);
      chk("egress hold", 32'(egressHold), 32'h05);
      rd(`PFC_REG_STATUS);
      chk("stop status", 32'(d[15:8]), 32'h05);
      for (int j = 0; j < 3000 && stopIndication[0] !== 1'b0; j++) @(posedge clk);
      // Quantum grid runs free, so a pause may end up to one quantum early
      chk("pause length", near(cyc - t0, 2050 - 256 / 10 ** s, 256 / 10 ** s + 3), 32'h1);
    end
    rd(`PFC_REG_RX_CNT);
    chk("pfc rx count", d, 32'h4);
    rxFrame(8'hff, 16'h0100, 1'b0);
    repeat (4) @(posedge clk);
    chk("no stop", 32'(stopIndication), 32'h0);
    wr(`PFC_REG_CTRL, ctrl(2'h0, 1'b0, 1'b0));
    rxFrame(8'hff, 16'h0100, 1'b1);
    repeat (4) @(posedge clk);
    chk("no stop", 32'(stopIndication), 32'h0);
    rd(`PFC_REG_RX_CNT);
    chk("pfc rx count", d, 32'h5);
    conclude();
  end
endmodule : tb_priority_flow_control_unit
bind priority_flow_control_unit pfc_chk #(.PRIOS(PRIOS)) i_pfc_chk (.clk(clk), .resetn(resetn),
  .read(read), .write(write), .waitrequest(waitrequest),
  .perPriorityCongestionVector(perPriorityCongestionVector), .txValid(txValid),
  .txData(txData), .txLast(txLast), .txReady(txReady), .rxValid(rxValid), .rxLast(rxLast),
  .stopIndication(stopIndication), .egressHold(egressHold));
`default_nettype wire
